// ===== spm_port.sv
// Serial master/slave port: core logic on clk, slave shifter on the incoming serial clock.
// Assumes software strobes arrive on clk; serial pins are asynchronous to clk.
module spm_port (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Software access
  input wire spm_pkg::spm_cpu_t cpu,
  output logic [7:0] serial_control_reg,
  output logic [7:0] serial_status_ctrl_reg,
  output logic [7:0] serial_data_reg,
  output logic xfer_irq,
  output logic mode_fault_flag_irq,
  // Serial clock pin; input doubles as the slave link clock
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  // Data pins
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  // Select pin, active low
  input wire logic ss_n_in
);

  `include "spm_defs.svh"

  // Half period in clk cycles: divisor 4 gives 2, divisor 128 gives 64
  function automatic logic [6:0] spm_half(input logic [2:0] code);
    spm_half = 7'h01 << code;
  endfunction

  // Codes 000 and 111 have no divisor
  function automatic logic spm_rate_ok(input logic [2:0] code);
    spm_rate_ok = (code != `SPM_RATE_OFF_LO) && (code != `SPM_RATE_OFF_HI);
  endfunction

  spm_pkg::spm_st_t s, n;
  spm_pkg::spm_lk_t l, nl;
  spm_pkg::spm_lko_t lo, nlo;

  logic [2:0] rate;
  logic en, master_select_bit, select_pin_disable, cpol, cpha;
  logic slave_act, ss_pin_eff, lk_rst_n, lk_clk;
  logic m_fin, rx_evt, sl_evt, m_load, lead, samp;
  logic [7:0] m_byte, rx_byte;

  // Decoded control fields
  assign rate = {s.ctrl[`SPM_CB_RATE2], s.ctrl[`SPM_CB_RATE1], s.ctrl[`SPM_CB_RATE0]};
  assign en = s.ctrl[`SPM_CB_EN];
  assign master_select_bit = s.ctrl[`SPM_CB_MASTER_SELECT_BIT];
  assign select_pin_disable = s.ctrl[`SPM_CB_SELECT_PIN_DISABLE];
  assign cpol = s.ctrl[`SPM_CB_CPOL];
  assign cpha = s.ctrl[`SPM_CB_CPHA];
  assign slave_act = en & ~master_select_bit;

  // Link clock: sample edge becomes a rising edge in all four formats
  assign lk_clk = sck_in ^ cpol ^ cpha;
  // Select disabled means always selected in slave mode
  assign ss_pin_eff = ~select_pin_disable & ss_n_in;
  // Select high holds the slave shifter in reset, so clock edges are ignored
  assign lk_rst_n = nrst & slave_act & ~ss_pin_eff;

  // Slave shifter: counter and partial byte
  always_comb begin
    nl = l;
    nl.cnt = l.cnt + 3'h1;
    nl.sh = {l.sh[5:0], mosi_in};
  end

  // Finished byte and toggle survive deselect so no false event is seen
  always_comb begin
    nlo = lo;
    if (l.cnt == `SPM_LAST_BIT) begin
      nlo.rx = {l.sh, mosi_in};
      nlo.tg = ~lo.tg;
    end
  end

  // Link domain registers
  always_ff @(posedge lk_clk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      l <= '0;
    end else begin
      l <= nl;
    end
  end

  always_ff @(posedge lk_clk or negedge nrst) begin
    if (!nrst) begin
      lo <= '0;
    end else begin
      lo <= nlo;
    end
  end

  // Core domain next state
  always_comb begin
    n = s;
    m_fin = 1'b0;
    m_load = 1'b0;
    m_byte = s.rxs;
    lead = 1'b0;
    samp = 1'b0;
    rx_evt = 1'b0;
    rx_byte = lo.rx;
    // Two-flop synchronisers and edge history
    n.ss_m = ss_n_in;
    n.ss_s = s.ss_m;
    n.ss_prev = s.ss_s;
    n.miso_m = miso_in;
    n.miso_s = s.miso_m;
    n.tg_m = lo.tg;
    n.tg_s = s.tg_m;
    n.tg_prev = s.tg_s;
    sl_evt = slave_act & (s.tg_s ^ s.tg_prev);

    // Status read arms the clear sequences; overrun clears on the read itself
    if (cpu.stat_rd) begin
      n.done_arm = s.done;
      n.mode_fault_flag_arm = s.mode_fault_flag;
      n.ovr = 1'b0;
    end
    if (cpu.stat_wr) begin
      n.ie = cpu.wdata[`SPM_SB_TXIE:`SPM_SB_MFIE];
    end
    // Enable cannot be set while an unacknowledged fault stands
    if (cpu.ctrl_wr) begin
      n.ctrl = cpu.wdata;
      if (s.mode_fault_flag && !s.mode_fault_flag_arm) begin
        n.ctrl[`SPM_CB_EN] = 1'b0;
      end
      if (s.mode_fault_flag_arm) begin
        n.mode_fault_flag = 1'b0;
        n.mode_fault_flag_arm = 1'b0;
      end
    end
    if ((cpu.data_rd || cpu.data_wr) && s.done_arm) begin
      n.done = 1'b0;
      n.done_arm = 1'b0;
    end

    // Master sequencer: sixteen half periods of the divided clock
    case (s.mst)
      spm_pkg::ST_IDLE: begin
        n.sck = cpol;
        m_load = en & master_select_bit & s.txfull & spm_rate_ok(rate);
      end
      spm_pkg::ST_XFER: begin
        if (s.div == spm_half(rate) - 7'h01) begin
          n.div = 7'h00;
          n.half = s.half + 4'h1;
          n.sck = ~s.sck;
          lead = ~s.half[0];
          samp = lead ^ cpha;
          if (samp) begin
            n.rxs = {s.rxs[6:0], s.miso_s};
          end else begin
            n.mosi = s.txs[7];
            n.txs = {s.txs[6:0], 1'b0};
          end
          if (s.half == `SPM_LAST_HALF) begin
            m_fin = 1'b1;
            m_byte = cpha ? {s.rxs[6:0], s.miso_s} : s.rxs;
            m_load = s.txfull;
            if (!s.txfull) begin
              n.mst = spm_pkg::ST_IDLE;
            end
          end
        end else begin
          n.div = s.div + 7'h01;
        end
      end
      default: n.mst = spm_pkg::ST_IDLE;
    endcase

    // Load the queued byte into the shifter; phase zero shows the MSB at once
    if (m_load) begin
      n.mst = spm_pkg::ST_XFER;
      n.div = 7'h00;
      n.half = 4'h0;
      n.rxs = 8'h00;
      n.txfull = 1'b0;
      if (cpha) begin
        n.txs = s.txbuf;
      end else begin
        n.mosi = s.txbuf[7];
        n.txs = {s.txbuf[6:0], 1'b0};
      end
    end
    // Disable or leaving master mode aborts the transfer
    if (!en || !master_select_bit) begin
      n.mst = spm_pkg::ST_IDLE;
    end

    // Slave transmit holding byte: loads only between transfers or at a byte end
    if (sl_evt) begin
      n.txhold = s.txfull ? s.txbuf : lo.rx;
      n.txfull = 1'b0;
    end else if (slave_act && s.txfull && !select_pin_disable && s.ss_s) begin
      n.txhold = s.txbuf;
      n.txfull = 1'b0;
    end

    // Received byte: set wins over any clear this cycle
    rx_evt = m_fin | sl_evt;
    rx_byte = m_fin ? m_byte : lo.rx;
    if (rx_evt) begin
      if (s.done && !(n.done == 1'b0 && s.done_arm)) begin
        n.ovr = 1'b1;
      end else begin
        n.rxdata = rx_byte;
        n.done = 1'b1;
      end
    end

    // Software write queues a byte last, so it is never lost to a load
    if (cpu.data_wr) begin
      n.txbuf = cpu.wdata;
      n.txfull = 1'b1;
    end

    // Slave transfer window: opens on a select fall, closes at the byte end.
    // With phase one and select held low, later bytes do not reopen it.
    if (!slave_act || select_pin_disable) begin
      n.sel_busy = 1'b0;
    end else if (!s.ss_s && s.ss_prev) begin
      n.sel_busy = 1'b1;
    end else if (sl_evt || s.ss_s) begin
      n.sel_busy = 1'b0;
    end

    // Mode faults; none while select use is disabled
    if (!select_pin_disable) begin
      if (en && master_select_bit && !s.ss_s) begin
        n.mode_fault_flag = 1'b1;
        n.ctrl[`SPM_CB_EN] = 1'b0;
        n.ctrl[`SPM_CB_MASTER_SELECT_BIT] = 1'b0;
        n.mst = spm_pkg::ST_IDLE;
      end else if (slave_act && s.ss_s && !s.ss_prev && s.sel_busy) begin
        n.mode_fault_flag = 1'b1;
      end
    end

    // Requests follow the flags in the same cycle
    n.oe_m = n.ctrl[`SPM_CB_EN] & n.ctrl[`SPM_CB_MASTER_SELECT_BIT];
    n.xirq = n.ie[1] ? ~n.txfull : n.done;
    n.mirq = n.mode_fault_flag & n.ie[0] & ~n.ctrl[`SPM_CB_SELECT_PIN_DISABLE];
  end

  // Core domain registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.ctrl <= `SPM_CTRL_RST;
      s.ss_m <= 1'b1;
      s.ss_s <= 1'b1;
      s.ss_prev <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs; the slave data pin follows the link counter so bit 7 is ready pre-edge
  assign serial_control_reg = s.ctrl;
  assign serial_status_ctrl_reg = {s.done, 1'b0, s.ovr, s.mode_fault_flag, ~s.txfull, 1'b0, s.ie};
  assign serial_data_reg = s.rxdata;
  assign xfer_irq = s.xirq;
  assign mode_fault_flag_irq = s.mirq;
  assign sck_out = s.sck;
  assign sck_oe = s.oe_m;
  assign mosi_out = s.mosi;
  assign mosi_oe = s.oe_m;
  assign miso_out = s.txhold[~l.cnt];
  assign miso_oe = lk_rst_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  master_start_a: assert property (
    (s.mst == spm_pkg::ST_IDLE && en && master_select_bit && s.txfull && spm_rate_ok(rate)
     && (s.ss_s || select_pin_disable)) |=> (s.mst == spm_pkg::ST_XFER && s.half == 4'h0))
    else $error("master did not start on queued byte");
  done_latch_a: assert property (
    (m_fin && !s.done) |=> (s.done && s.rxdata == $past(m_byte)))
    else $error("done or received byte missing at master end");
  done_clear_a: assert property (
    $fell(s.done) |-> $past(s.done_arm && (cpu.data_rd || cpu.data_wr)))
    else $error("done cleared without read sequence");
  overrun_keep_a: assert property (
    (rx_evt && s.done && !s.done_arm) |=> (s.ovr && $stable(s.rxdata)))
    else $error("overrun lost or old byte overwritten");
  master_fault_a: assert property (
    (en && master_select_bit && !select_pin_disable && !s.ss_s) |=> (s.mode_fault_flag && !en && !master_select_bit))
    else $error("master fault did not disable port");
  fault_clear_a: assert property (
    $fell(s.mode_fault_flag) |-> $past(s.mode_fault_flag_arm && cpu.ctrl_wr))
    else $error("fault cleared without sequence");
  idle_level_a: assert property (
    (s.mst == spm_pkg::ST_IDLE) |=> (s.sck == $past(cpol)))
    else $error("idle clock level wrong");
  no_fault_a: assert property (
    (select_pin_disable && !s.mode_fault_flag && !cpu.ctrl_wr) |=> !s.mode_fault_flag)
    else $error("fault while select disabled");
  fault_irq_a: assert property (
    s.mirq |-> (!select_pin_disable && s.mode_fault_flag))
    else $error("fault request while select disabled");
  back_to_back_a: assert property (
    (m_fin && s.txfull && en && master_select_bit && (s.ss_s || select_pin_disable) && !cpu.data_wr)
    |=> (s.mst == spm_pkg::ST_XFER && s.half == 4'h0 && !s.txfull))
    else $error("queued byte not sent back to back");
  fast_rate_a: assert property (
    ($changed(s.sck) && s.mst == spm_pkg::ST_XFER && s.half != 4'h0
     && rate == `SPM_RATE_DIV4 && !cpu.ctrl_wr)
    |-> ##1 $stable(s.sck) ##1 ($changed(s.sck) || s.mst != spm_pkg::ST_XFER || !en))
    else $error("divide by four half period wrong");
  slave_echo_a: assert property (
    (sl_evt && !s.txfull) |=> (s.txhold == $past(lo.rx)))
    else $error("slave did not echo received byte");
  slave_fault_a: assert property (
    (slave_act && !select_pin_disable && s.ss_s && !s.ss_prev && s.sel_busy) |=> s.mode_fault_flag)
    else $error("slave fault missed on select rise");

  master_done_c: cover property (m_fin);
  slave_done_c: cover property (sl_evt);
  queued_c: cover property (m_fin && s.txfull);
  overrun_c: cover property (rx_evt && s.done);
  fault_c: cover property ($rose(s.mode_fault_flag));

endmodule

// ===== spm_defs.svh
// Constants for the serial master/slave port: control and status bit positions,
// reset values and serial counts. Included by bare name; definitions only.
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH
// Control byte layout
`define SPM_CB_RATE2 7
`define SPM_CB_EN 6
`define SPM_CB_SELECT_PIN_DISABLE 5
`define SPM_CB_MASTER_SELECT_BIT 4
`define SPM_CB_CPOL 3
`define SPM_CB_CPHA 2
`define SPM_CB_RATE1 1
`define SPM_CB_RATE0 0
`define SPM_CTRL_RST 8'h14
// Status and control byte layout
`define SPM_SB_DONE 7
`define SPM_SB_OVR 5
`define SPM_SB_MODE_FAULT_FLAG 4
`define SPM_SB_EMPTY 3
`define SPM_SB_TXIE 1
`define SPM_SB_MFIE 0
// Rate codes that have no divisor, and the fastest one
`define SPM_RATE_OFF_LO 3'h0
`define SPM_RATE_OFF_HI 3'h7
`define SPM_RATE_DIV4 3'h1
// Serial counts: eight bits, sixteen half periods
`define SPM_LAST_BIT 3'h7
`define SPM_LAST_HALF 4'hf
`endif

// ===== spm_pkg.sv
// Types shared by the serial master/slave port.
// Assumes spm_defs.svh supplies the numeric constants.
package spm_pkg;

  // Master sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_XFER = 1'b1
  } spm_mst_t;

  // Software access strobes with their write byte
  typedef struct packed {
    logic ctrl_wr;
    logic stat_rd;
    logic stat_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wdata;
  } spm_cpu_t;

  // Whole state of the core clock domain
  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] ie;
    logic [7:0] txbuf;
    logic txfull;
    logic [7:0] rxdata;
    logic done;
    logic ovr;
    logic mode_fault_flag;
    logic done_arm;
    logic mode_fault_flag_arm;
    spm_mst_t mst;
    logic [6:0] div;
    logic [3:0] half;
    logic [7:0] txs;
    logic [7:0] rxs;
    logic sck;
    logic mosi;
    logic oe_m;
    logic [7:0] txhold;
    logic ss_m;
    logic ss_s;
    logic ss_prev;
    logic miso_m;
    logic miso_s;
    logic tg_m;
    logic tg_s;
    logic tg_prev;
    logic xirq;
    logic mirq;
    logic sel_busy;
  } spm_st_t;

  // Link-side bit counter and partial byte, cleared while deselected
  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sh;
  } spm_lk_t;

  // Link-side finished byte and its event toggle, kept across deselect
  typedef struct packed {
    logic [7:0] rx;
    logic tg;
  } spm_lko_t;

endpackage

// ===== spm_far.sv
// Far-side model of the serial port: an external master, and a listening slave.
// Assumes the bench resolves the shared pins and keeps the link clock stopped between frames.
module spm_far (
  // Resolved serial pins
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  // Format shared with the port
  input wire logic cpol,
  input wire logic cpha,
  // Pins driven as master
  output logic sck_m,
  output logic mosi_m,
  output logic ss_n,
  // Pin driven as slave
  output logic miso_s
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] s_tx;
  logic [15:0] s_rx;
  logic [4:0] s_k;
  wire lk = sck ^ cpol ^ cpha;
  // Slave answer; after the frame the line shows the inverse, not a stale bit
  assign miso_s = (s_k < 5'h10) ? s_tx[4'hf - s_k[3:0]] : ~s_tx[0];
  // Sample edge follows polarity and phase; next bit shown at once, which is harsh on hold
  always @(posedge lk) begin
    s_rx <= {s_rx[14:0], mosi};
    s_k <= s_k + 5'h1;
  end
  // Idle pins at start
  initial begin
    sck_m = 1'b0;
    mosi_m = 1'b0;
    ss_n = 1'b1;
  end
  task automatic s_load(input logic [15:0] v);
    s_tx = v;
    s_rx = '0;
    s_k = '0;
  endtask
  task automatic set_ss(input logic v);
    ss_n = v;
  endtask
  // One byte as master at a 160 ns link period, offset from the core clock edges
  task automatic m_xfer(input logic [7:0] tx, input logic keep, output logic [7:0] rx);
    #3;
    ss_n = 1'b0;
    sck_m = cpol;
    for (int i = 7; i >= 0; i--) begin
      if (!cpha) mosi_m = tx[i];
      #80;
      if (!cpha) rx[i] = miso;
      sck_m = ~cpol;
      if (cpha) mosi_m = tx[i];
      #80;
      if (cpha) rx[i] = miso;
      sck_m = cpol;
    end
    #80;
    mosi_m = ~tx[0];
    ss_n = ~keep;
    #80;
  endtask
endmodule

// ===== tb_spm_port.sv
// Self-checking bench for the serial master/slave port.
// Assumes spm_far stands on the serial pins; the bench resolves each shared line.
module tb_spm_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] CW = 5'h10, SR = 5'h08, SW = 5'h04, DW = 5'h02, DR = 5'h01;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  spm_pkg::spm_cpu_t cpu = '0;
  logic [7:0] ctl, sts, dat;
  logic xirq, mirq, sck_o, sck_e, mosi_o, mosi_e, miso_o, miso_e, sck_m, mosi_m, ss_n, miso_s;
  int fails = 0;
  int checks_done = 0;
  wire sck = sck_e ? sck_o : sck_m;
  wire mosi = mosi_e ? mosi_o : mosi_m;
  wire miso = miso_e ? miso_o : miso_s;
  // Core clock
  always #5 clk = ~clk;
  spm_port u_spm_port (.clk(clk), .nrst(nrst), .cpu(cpu), .serial_control_reg(ctl),
    .serial_status_ctrl_reg(sts), .serial_data_reg(dat), .xfer_irq(xirq), .mode_fault_flag_irq(mirq),
    .sck_in(sck), .sck_out(sck_o), .sck_oe(sck_e), .mosi_in(mosi), .mosi_out(mosi_o),
    .mosi_oe(mosi_e), .miso_in(miso), .miso_out(miso_o), .miso_oe(miso_e), .ss_n_in(ss_n));
  spm_far u_spm_far (.sck(sck), .mosi(mosi), .miso(miso), .cpol(ctl[3]), .cpha(ctl[2]),
    .sck_m(sck_m), .mosi_m(mosi_m), .ss_n(ss_n), .miso_s(miso_s));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] b(input logic v);
    return {7'h0, v};
  endfunction
  // One strobe pulse, then settle to the falling edge so outputs are read stable
  task automatic op(input logic [4:0] s, input logic [7:0] d);
    @(posedge clk) cpu <= {s, d};
    @(posedge clk) cpu <= '0;
    @(negedge clk);
  endtask
  task automatic wait_flag(input int k, output int n);
    for (n = 0; n < 2000 && sts[k] !== 1'b1; n++) @(negedge clk);
    check(b(sts[k]), 8'h01);
  endtask
  task automatic clr_done;
    op(SR, 8'h00);
    op(DR, 8'h00);
  endtask
  task automatic t_master;
    logic [2:0] r;
    int n;
    for (int m = 0; m < 4; m++) begin
      r = 3'(m + 1);
      op(CW, 8'h10);
      op(CW, {r[2], 3'b001, m[1:0], r[1:0]});
      op(CW, {r[2], 3'b101, m[1:0], r[1:0]});
      u_spm_far.s_load({8'h3c ^ 8'(m), 8'h00});
      op(DW, 8'ha5 ^ 8'(m));
      wait_flag(7, n);
      check(dat, 8'h3c ^ 8'(m));
      check(u_spm_far.s_rx[7:0], 8'ha5 ^ 8'(m));
      check(b(n >= (32 << m) - 4 && n <= (32 << m) + 8), 8'h01);
      check(b(sck), b(m[1]));
      check(b(xirq), 8'h01);
      clr_done;
      check(b(sts[7]), 8'h00);
    end
  endtask
  // Two bytes back to back; the second lands while the first is unread
  task automatic t_queue;
    int n;
    op(CW, 8'h11);
    op(CW, 8'h51);
    u_spm_far.s_load(16'h817e);
    op(DW, 8'hc3);
    op(DW, 8'h5a);
    check(b(sts[3]), 8'h00);
    wait_flag(5, n);
    check(b(n <= 65), 8'h01);
    check(u_spm_far.s_rx[15:8], 8'hc3);
    check(u_spm_far.s_rx[7:0], 8'h5a);
    check(dat, 8'h81);
    check(b(sts[3]), 8'h01);
    clr_done;
    check(sts & 8'ha0, 8'h00);
  endtask
  task automatic t_slave;
    logic [7:0] rx;
    int n;
    for (int ph = 0; ph < 2; ph++) begin
      op(CW, ctl & 8'hbf);
      op(CW, {5'b00000, ph[0], 2'b00});
      op(CW, {5'b01000, ph[0], 2'b00});
      op(DW, 8'h96);
      u_spm_far.m_xfer(8'h4b, ph[0], rx);
      check(rx, 8'h96);
      wait_flag(7, n);
      check(dat, 8'h4b);
      clr_done;
      u_spm_far.m_xfer(8'hd2, 1'b0, rx);
      check(rx, 8'h4b);
      wait_flag(7, n);
      check(dat, 8'hd2);
      check(b(miso_e), 8'h00);
      check(b(sts[4]), 8'h00);
      clr_done;
    end
  endtask
  task automatic t_faults;
    op(CW, 8'h04);
    op(CW, 8'h44);
    u_spm_far.set_ss(1'b0);
    #400;
    check(b(miso_e), 8'h01);
    u_spm_far.set_ss(1'b1);
    repeat (6) @(negedge clk);
    check(b(sts[4]), 8'h01);
    check(b(miso_e), 8'h00);
    op(SR, 8'h00);
    op(CW, 8'h10);
    check(b(sts[4]), 8'h00);
    op(SW, 8'h01);
    op(CW, 8'h50);
    u_spm_far.set_ss(1'b0);
    repeat (6) @(negedge clk);
    check(ctl & 8'h50, 8'h00);
    check(b(sts[4] & mirq), 8'h01);
    u_spm_far.set_ss(1'b1);
    op(SR, 8'h00);
    op(CW, 8'h30);
    check(b(sts[4] | mirq), 8'h00);
    op(CW, 8'h70);
    u_spm_far.set_ss(1'b0);
    repeat (6) @(negedge clk);
    check(ctl, 8'h70);
    check(b(sts[4] | mirq), 8'h00);
    u_spm_far.set_ss(1'b1);
    op(SW, 8'h02);
    check(b(xirq), 8'h01);
    op(SW, 8'h00);
    check(b(xirq), 8'h00);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence; the invalid rate code goes last since it leaves a byte queued
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check(ctl, 8'h14);
    check(sts, 8'h08);
    check(b(sck_e | mosi_e | miso_e | xirq | mirq), 8'h00);
    t_master;
    t_queue;
    t_slave;
    t_faults;
    op(CW, 8'h10);
    op(CW, 8'h50);
    op(DW, 8'h11);
    repeat (40) @(negedge clk);
    check(b(sts[7] | sck), 8'h00);
    print_verdict;
  end
  // Watchdog about fifteen times the expected run of some thirteen hundred cycles
  initial begin
    #200_000;
    fails++;
    print_verdict;
  end
endmodule
